// ===== core/mq_read_pkg.sv
// Shared constants and types of the multi-queue read port
package mq_read_pkg;
	localparam int QUEUE_COUNT = 8;
	localparam int QUEUE_BITS = 3;
	localparam int DATA_WIDTH = 36;
	localparam int SELECT_WIDTH = 7;
	localparam int QSEL_LSB = 0;
	localparam int QSEL_MSB = 2;
	localparam int NULL_BIT = 3;
	localparam int DEV_LSB = 4;
	localparam int DEV_MSB = 6;
	localparam int DEFAULT_DEPTH = 16;
	localparam int AEMPTY_LEVEL = 2;
	localparam int PACKET_LEVEL = 4;
	localparam logic [2:0] DEVICE_ID_DEFAULT = 3'h0;
	localparam logic [2:0] POLL_LAST_SLOT = 3'h7;
	localparam logic [2:0] QUEUE_RESET = 3'h0;
	localparam logic [7:0] FLAGS_RESET = 8'hFF;
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_PREV = 2'h1,
		PH_NEW = 2'h3
	} phase_t;
endpackage

// ===== core/queue_port_if.sv
// Carrier between read control and queue storage
`timescale 1ns/1ps
`default_nettype none
interface queue_port_if #(parameter int WIDTH = 36);
	logic pop;
	logic [2:0] popQueue;
	logic [WIDTH-1:0] headData;
	logic [7:0] empty;
	logic [7:0] almostEmpty;
	logic [7:0] packetReady;
	modport store (input pop, input popQueue, output headData, output empty,
		output almostEmpty, output packetReady);
	modport reader (output pop, output popQueue, input headData, input empty,
		input almostEmpty, input packetReady);
endinterface
`default_nettype wire

// ===== core/queue_store.sv
// Eight-queue storage with per-queue pointers and levels
`timescale 1ns/1ps
`default_nettype none
module queue_store
	import mq_read_pkg::*;
#(
	parameter int WIDTH = DATA_WIDTH,
	parameter int DEPTH = DEFAULT_DEPTH,
	parameter int AE_LEVEL = AEMPTY_LEVEL,
	parameter int PR_LEVEL = PACKET_LEVEL
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Write side
	input wire logic writeEnable,
	input wire logic [2:0] writeQueue,
	input wire logic [WIDTH-1:0] writeData,
	// Read side
	queue_port_if.store port
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [QUEUE_COUNT][DEPTH];
	logic [PW-1:0] wrPtr_r [QUEUE_COUNT];
	logic [PW-1:0] rdPtr_r [QUEUE_COUNT];
	logic [CW-1:0] count_r [QUEUE_COUNT];
	logic [PW-1:0] wrPtr_nxt [QUEUE_COUNT];
	logic [PW-1:0] rdPtr_nxt [QUEUE_COUNT];
	logic [CW-1:0] count_nxt [QUEUE_COUNT];
	logic doWrite;
	logic doRead;

	assign doWrite = writeEnable && (count_r[writeQueue] != FULL_COUNT);
	assign doRead = port.pop && (count_r[port.popQueue] != '0);
	assign port.headData = mem[port.popQueue][rdPtr_r[port.popQueue]];

	always_comb begin
		for (int q = 0; q < QUEUE_COUNT; q++) begin
			wrPtr_nxt[q] = wrPtr_r[q];
			rdPtr_nxt[q] = rdPtr_r[q];
			count_nxt[q] = count_r[q];
			if (doWrite && writeQueue == q[2:0]) begin
				wrPtr_nxt[q] = wrPtr_r[q] + PW'(1);
			end
			if (doRead && port.popQueue == q[2:0]) begin
				rdPtr_nxt[q] = rdPtr_r[q] + PW'(1);
			end
			if (doWrite && writeQueue == q[2:0] && !(doRead && port.popQueue == q[2:0])) begin
				count_nxt[q] = count_r[q] + CW'(1);
			end else if (!(doWrite && writeQueue == q[2:0]) && doRead
				&& port.popQueue == q[2:0]) begin
				count_nxt[q] = count_r[q] - CW'(1);
			end
			port.empty[q] = (count_r[q] == '0);
			port.almostEmpty[q] = (count_r[q] <= CW'(AE_LEVEL));
			port.packetReady[q] = (count_r[q] >= CW'(PR_LEVEL));
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int q = 0; q < QUEUE_COUNT; q++) begin
				wrPtr_r[q] <= '0;
				rdPtr_r[q] <= '0;
				count_r[q] <= '0;
			end
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (doWrite) begin
			mem[writeQueue][wrPtr_r[writeQueue]] <= writeData;
		end
	end
endmodule
`default_nettype wire

// ===== core/multi_queue_read_port_select.sv
// Read port control: queue select, fall-through latency, flag bus and expansion
//
// Functional notes
// - Latch select bus when queue strobe high
// - Read strobe low pops selected queue
// - Flags and flag bus timed by clock
// - Seven-bit bus, low three pick queue
// - Bit three selects the null queue
// - High bits pick device by identity
// - Select edge may still read old queue
// - First edge after: forced old word
// - Second edge after: new queue fall-through
// - Strobed mode: high bits pick flag device
// - Latch flag device on flag strobe
// - Queue select ignores the read strobe
// - Flag bus needs no read strobe
// - Expansion signals timed by read clock
// - Drive output only when enabled, selected
`timescale 1ns/1ps
`default_nettype none
module multi_queue_read_port_select
	import mq_read_pkg::*;
#(
	parameter logic [2:0] DEVICE_ID = DEVICE_ID_DEFAULT,
	parameter int DEPTH = DEFAULT_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Read control
	input wire logic [SELECT_WIDTH-1:0] readSelectBus,
	input wire logic readQueueSelectStrobe,
	input wire logic flagDeviceStrobe,
	input wire logic readEnable_n,
	input wire logic outputEnable_n,
	// Write feed
	input wire logic writeEnable,
	input wire logic [2:0] writeQueue,
	input wire logic [DATA_WIDTH-1:0] writeData,
	// Configuration and programming
	input wire logic polledFlagMode,
	input wire logic configDone,
	input wire logic serialInEnable_n,
	output logic programDoneOut_n,
	// Expansion
	input wire logic expansionIn,
	output logic expansionOut,
	// Data out
	output logic [DATA_WIDTH-1:0] qOut,
	output logic qOutEn,
	output logic outputValidFlag,
	// Flags
	output logic almostEmptyFlag_n,
	output logic packetReadyFlag_n,
	output logic [7:0] flagBusOut,
	output logic flagBusEn,
	output logic flagBusSync
);
	queue_port_if #(.WIDTH(DATA_WIDTH)) qp ();

	queue_store #(.WIDTH(DATA_WIDTH), .DEPTH(DEPTH)) store (
		.clock(clock),
		.arst_n(arst_n),
		.writeEnable(writeEnable),
		.writeQueue(writeQueue),
		.writeData(writeData),
		.port(qp.store)
	);

	function automatic logic idMatch(input logic [SELECT_WIDTH-1:0] bus);
		return bus[DEV_MSB:DEV_LSB] == DEVICE_ID;
	endfunction

	// ----------------------------------------------------------------
	// Queue selection and fall-through sequencing
	// ----------------------------------------------------------------
	phase_t phase_r, phase_nxt;
	logic [2:0] curQueue_r, curQueue_nxt, oldQueue_r, oldQueue_nxt;
	logic nullSel_r, nullSel_nxt, oldNull_r, oldNull_nxt;
	logic devSel_r, devSel_nxt, oldDev_r, oldDev_nxt;
	logic selEdge, curActive, oldActive;

	assign selEdge = readQueueSelectStrobe;
	assign curActive = devSel_r && !nullSel_r && !qp.empty[curQueue_r];
	assign oldActive = oldDev_r && !oldNull_r && !qp.empty[oldQueue_r];

	always_comb begin
		phase_nxt = phase_r;
		curQueue_nxt = curQueue_r;
		nullSel_nxt = nullSel_r;
		devSel_nxt = devSel_r;
		oldQueue_nxt = oldQueue_r;
		oldNull_nxt = oldNull_r;
		oldDev_nxt = oldDev_r;
		unique case (phase_r)
			PH_IDLE: phase_nxt = PH_IDLE;
			PH_PREV: phase_nxt = PH_NEW;
			PH_NEW: phase_nxt = PH_IDLE;
		endcase
		// latch on strobe, read strobe not involved
		if (selEdge) begin
			oldQueue_nxt = curQueue_r;
			oldNull_nxt = nullSel_r;
			oldDev_nxt = devSel_r;
			phase_nxt = PH_PREV;
			// only the matching device takes it
			devSel_nxt = idMatch(readSelectBus);
			if (idMatch(readSelectBus)) begin
				curQueue_nxt = readSelectBus[QSEL_MSB:QSEL_LSB];
				nullSel_nxt = readSelectBus[NULL_BIT];
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= PH_IDLE;
			curQueue_r <= QUEUE_RESET;
			oldQueue_r <= QUEUE_RESET;
			nullSel_r <= 1'b1;
			oldNull_r <= 1'b1;
			devSel_r <= 1'b0;
			oldDev_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			curQueue_r <= curQueue_nxt;
			oldQueue_r <= oldQueue_nxt;
			nullSel_r <= nullSel_nxt;
			oldNull_r <= oldNull_nxt;
			devSel_r <= devSel_nxt;
			oldDev_r <= oldDev_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pop decision
	// ----------------------------------------------------------------
	always_comb begin
		qp.pop = 1'b0;
		qp.popQueue = curQueue_r;
		unique case (phase_r)
			// normal read, old queue still on a select edge
			PH_IDLE: qp.pop = !readEnable_n && curActive;
			// one forced word from the previous queue
			PH_PREV: begin
				qp.pop = oldActive;
				qp.popQueue = oldQueue_r;
			end
			// fall-through of the new queue's first word
			PH_NEW: qp.pop = curActive;
		endcase
	end

	// ----------------------------------------------------------------
	// Output data and flags
	// ----------------------------------------------------------------
	logic [DATA_WIDTH-1:0] qOut_r, qOut_nxt;
	logic qOutEn_r, qOutEn_nxt, valid_r, valid_nxt;
	logic aeFlag_r, aeFlag_nxt, prFlag_r, prFlag_nxt;

	always_comb begin
		qOut_nxt = qp.pop ? qp.headData : qOut_r;
		valid_nxt = qp.pop;
		// drive only with output enable low and a queue selected
		qOutEn_nxt = !outputEnable_n && devSel_r && !nullSel_r;
		aeFlag_nxt = aeFlag_r;
		prFlag_nxt = prFlag_r;
		if (devSel_r && !nullSel_r) begin
			aeFlag_nxt = !qp.almostEmpty[curQueue_r];
			prFlag_nxt = !qp.packetReady[curQueue_r];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			qOut_r <= '0;
			qOutEn_r <= 1'b0;
			valid_r <= 1'b0;
			aeFlag_r <= 1'b0;
			prFlag_r <= 1'b1;
		end else begin
			qOut_r <= qOut_nxt;
			qOutEn_r <= qOutEn_nxt;
			valid_r <= valid_nxt;
			aeFlag_r <= aeFlag_nxt;
			prFlag_r <= prFlag_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Flag bus, expansion and programming status
	// ----------------------------------------------------------------
	logic flagOwner_r, flagOwner_nxt;
	logic [2:0] pollSlot_r, pollSlot_nxt;
	logic [7:0] flagBus_r, flagBus_nxt;
	logic flagBusEn_r, flagBusEn_nxt, sync_r, sync_nxt, expOut_r, expOut_nxt;
	logic progDone_r, progDone_nxt;

	always_comb begin
		flagOwner_nxt = flagOwner_r;
		// device field only, low bits ignored
		if (flagDeviceStrobe) begin
			flagOwner_nxt = idMatch(readSelectBus);
		end
		// slot counter resynced from the expansion input
		pollSlot_nxt = expansionIn ? '0 : pollSlot_r + 3'h1;
		// bus runs from the clock alone
		flagBus_nxt = ~qp.almostEmpty;
		flagBusEn_nxt = polledFlagMode ? (pollSlot_r == DEVICE_ID) : flagOwner_r;
		sync_nxt = polledFlagMode && (pollSlot_r == '0);
		expOut_nxt = polledFlagMode && (pollSlot_r == POLL_LAST_SLOT);
		progDone_nxt = !(configDone && !serialInEnable_n);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flagOwner_r <= 1'b0;
			pollSlot_r <= '0;
			flagBus_r <= FLAGS_RESET;
			flagBusEn_r <= 1'b0;
			sync_r <= 1'b0;
			expOut_r <= 1'b0;
			progDone_r <= 1'b1;
		end else begin
			flagOwner_r <= flagOwner_nxt;
			pollSlot_r <= pollSlot_nxt;
			flagBus_r <= flagBus_nxt;
			flagBusEn_r <= flagBusEn_nxt;
			sync_r <= sync_nxt;
			expOut_r <= expOut_nxt;
			progDone_r <= progDone_nxt;
		end
	end

	assign qOut = qOut_r;
	assign qOutEn = qOutEn_r;
	assign outputValidFlag = valid_r;
	assign almostEmptyFlag_n = aeFlag_r;
	assign packetReadyFlag_n = prFlag_r;
	assign flagBusOut = flagBus_r;
	assign flagBusEn = flagBusEn_r;
	assign flagBusSync = sync_r;
	assign expansionOut = expOut_r;
	assign programDoneOut_n = progDone_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_select_mine;
		readQueueSelectStrobe && idMatch(readSelectBus);
	endsequence

	sequence s_new_ready;
		phase_r == PH_NEW && curActive;
	endsequence

	a_queue_latch: assert property (@(posedge clock) disable iff (!arst_n)
		s_select_mine |=> curQueue_r == $past(readSelectBus[QSEL_MSB:QSEL_LSB]))
		else $error("queue not latched on strobe");
	a_null_latch: assert property (@(posedge clock) disable iff (!arst_n)
		s_select_mine |=> nullSel_r == $past(readSelectBus[NULL_BIT]))
		else $error("null bit not latched");
	a_id_filter: assert property (@(posedge clock) disable iff (!arst_n)
		readQueueSelectStrobe && !idMatch(readSelectBus) |=> !devSel_r)
		else $error("foreign device selection accepted");
	a_read_pop: assert property (@(posedge clock) disable iff (!arst_n)
		phase_r == PH_IDLE && !readEnable_n && curActive
		|-> qp.pop && qp.popQueue == curQueue_r ##1 valid_r)
		else $error("read strobe did not pop");
	a_prev_word: assert property (@(posedge clock) disable iff (!arst_n)
		readQueueSelectStrobe ##1 oldActive |-> qp.pop && qp.popQueue == oldQueue_r)
		else $error("previous queue word missing");
	a_new_word: assert property (@(posedge clock) disable iff (!arst_n)
		readQueueSelectStrobe ##1 !readQueueSelectStrobe ##1 s_new_ready
		|-> qp.pop && qp.popQueue == curQueue_r)
		else $error("fall-through word missing");
	a_null_nopop: assert property (@(posedge clock) disable iff (!arst_n)
		phase_r == PH_IDLE && nullSel_r |=> !valid_r && $stable(aeFlag_r))
		else $error("null queue popped or flag moved");
	a_flag_owner: assert property (@(posedge clock) disable iff (!arst_n)
		flagDeviceStrobe |=> flagOwner_r == $past(idMatch(readSelectBus)))
		else $error("flag device not latched");
	a_drive_qout: assert property (@(posedge clock) disable iff (!arst_n)
		qOutEn_r |-> $past(!outputEnable_n && devSel_r && !nullSel_r))
		else $error("output driven while not enabled");
	a_poll_sync: assert property (@(posedge clock) disable iff (!arst_n)
		polledFlagMode && !expansionIn && pollSlot_r == '0 |=> flagBusSync)
		else $error("flag bus sync missing");
endmodule
`default_nettype wire

// ===== test/reader_model.sv
// Reader-side model that drives the select bus and both strobes
`timescale 1ns/1ps
`default_nettype none
module reader_model (
	// Clock and programming status
	input wire logic clock,
	input wire logic programDoneOut_n,
	// Select outputs
	output logic [6:0] readSelectBus,
	output logic readQueueSelectStrobe,
	output logic flagDeviceStrobe
);
	initial begin
		readSelectBus = 7'h55;
		readQueueSelectStrobe = 1'b0;
		flagDeviceStrobe = 1'b0;
	end

	// Entered just after an edge; strobe is held over exactly one edge
	task automatic pulse(input logic [6:0] addr, input logic isFlag);
		readSelectBus = addr;
		flagDeviceStrobe = isFlag;
		readQueueSelectStrobe = !isFlag && programDoneOut_n === 1'b0;
		@(posedge clock);
		#1;
		// strobe only on the change cycle
		readQueueSelectStrobe = 1'b0;
		flagDeviceStrobe = 1'b0;
		// Released bus shows the inverse of its last value
		readSelectBus = ~addr;
	endtask
endmodule
`default_nettype wire

// ===== test/multi_queue_read_port_select_bench.sv
// Self-checking bench of the multi-queue read port
`timescale 1ns/1ps
`default_nettype none
module multi_queue_read_port_select_bench;
	import mq_read_pkg::*;
	localparam logic [2:0] MY_ID = 3'h5;
	logic clock, arst_n, readQueueSelectStrobe, flagDeviceStrobe, readEnable_n, outputEnable_n;
	logic writeEnable, polledFlagMode, configDone, serialInEnable_n, expansionIn;
	logic programDoneOut_n, expansionOut, qOutEn, outputValidFlag, almostEmptyFlag_n;
	logic packetReadyFlag_n, flagBusEn, flagBusSync, expV;
	logic [2:0] writeQueue;
	logic [SELECT_WIDTH-1:0] readSelectBus;
	logic [DATA_WIDTH-1:0] writeData, qOut, expQ;
	logic [7:0] flagBusOut;
	logic [9:0] flagSnap;
	logic [DATA_WIDTH-1:0] fifo [8][$];
	int n_mismatch = 0;
	int samples_checked = 0;
	int sel = -1;
	int cnt, nSync, nExo, nOwn;

	multi_queue_read_port_select #(.DEVICE_ID(MY_ID)) multi_queue_read_port_select_i (
		.clock, .arst_n, .readSelectBus, .readQueueSelectStrobe, .flagDeviceStrobe,
		.readEnable_n, .outputEnable_n, .writeEnable, .writeQueue, .writeData,
		.polledFlagMode, .configDone, .serialInEnable_n, .programDoneOut_n,
		.expansionIn, .expansionOut, .qOut, .qOutEn, .outputValidFlag,
		.almostEmptyFlag_n, .packetReadyFlag_n, .flagBusOut, .flagBusEn, .flagBusSync);

	reader_model reader_model_i (.clock, .programDoneOut_n, .readSelectBus,
		.readQueueSelectStrobe, .flagDeviceStrobe);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
		samples_checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic test_done();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Model retires the pop of the edge just passed and compares
	task automatic retire(input int popQ);
		expV = 1'b0;
		if (popQ >= 0 && fifo[popQ].size() > 0) begin
			expQ = fifo[popQ].pop_front();
			expV = 1'b1;
		end
		check(qOut, expQ, "data");
		check(outputValidFlag, expV, "valid");
	endtask

	task automatic tick(input int popQ);
		@(posedge clock);
		#1;
		retire(popQ);
	endtask

	task automatic reads(input int n, input logic rnd);
		repeat (n) begin
			readEnable_n = rnd ? 1'($urandom) : 1'b0;
			tick(readEnable_n ? -1 : sel);
		end
		readEnable_n = 1'b1;
	endtask

	// Selected queue flags against the model's fill level
	task automatic levels(input int q);
		tick(-1);
		check(almostEmptyFlag_n, fifo[q].size() > AEMPTY_LEVEL, "almost empty");
		check(packetReadyFlag_n, fifo[q].size() < PACKET_LEVEL, "packet ready");
	endtask

	task automatic selectQ(input logic [6:0] addr, input logic ren_n);
		int old;
		old = sel;
		readEnable_n = ren_n;
		reader_model_i.pulse(addr, 1'b0);
		// Forced words must not depend on the read strobe
		readEnable_n = 1'($urandom);
		// select edge may pop old queue
		retire(ren_n ? -1 : old);
		// queue, null bit and device id
		sel = (addr[6:4] === MY_ID && addr[3] === 1'b0) ? int'(addr[2:0]) : -1;
		tick(old);
		tick(sel);
		readEnable_n = 1'b1;
	endtask

	task automatic flagSel(input logic [6:0] addr, input logic want);
		reader_model_i.pulse(addr, 1'b1);
		tick(-1);
		check(flagBusEn, want, "owner");
	endtask

	initial begin
		#100000;
		n_mismatch++;
		test_done();
	end

	initial begin
		cnt = $urandom(32'hB35C);
		{arst_n, readEnable_n, outputEnable_n, serialInEnable_n} = 4'h7;
		{writeEnable, polledFlagMode, configDone, expansionIn, expV} = 5'h00;
		arst_n = 1'b0;
		writeQueue = 3'h0;
		writeData = '0;
		expQ = '0;
		repeat (6) @(posedge clock);
		#1;
		arst_n = 1'b1;
		check(flagBusOut, 8'hFF, "reset flags");
		check(qOutEn, 1'b0, "reset drive");
		configDone = 1'b1;
		serialInEnable_n = 1'b0;
		cnt = 0;
		while (programDoneOut_n !== 1'b0 && cnt < 20) begin
			tick(-1);
			cnt++;
		end
		check(programDoneOut_n, 1'b0, "programmed");
		for (int q = 0; q < 8; q++) begin
			for (int k = 0; k <= q; k++) begin
				writeEnable = 1'b1;
				writeQueue = 3'(q);
				writeData = {4'($urandom), 32'($urandom)};
				fifo[q].push_back(writeData);
				tick(-1);
			end
		end
		writeEnable = 1'b0;
		repeat (3) tick(-1);
		check(flagBusOut, 8'hFC, "level flags");
		outputEnable_n = 1'b0;
		selectQ(7'h57, 1'b1);
		check(qOutEn, 1'b1, "drive own");
		levels(7);
		selectQ(7'h55, 1'b0);
		reads(2, 1'b0);
		selectQ(7'h5A, 1'b1);
		tick(-1);
		check(qOutEn, 1'b0, "drive null");
		flagSnap = {almostEmptyFlag_n, packetReadyFlag_n, flagBusOut};
		reads(3, 1'b0);
		check({almostEmptyFlag_n, packetReadyFlag_n, flagBusOut}, flagSnap, "frozen");
		selectQ(7'h13, 1'b1);
		reads(2, 1'b0);
		check(qOutEn, 1'b0, "drive other");
		selectQ(7'h53, 1'b1);
		flagSel(7'h5F, 1'b1);
		flagSel(7'h28, 1'b0);
		flagSel(7'h50, 1'b1);
		reads(8, 1'b1);
		levels(3);
		polledFlagMode = 1'b1;
		expansionIn = 1'b1;
		tick(-1);
		expansionIn = 1'b0;
		{nSync, nExo, nOwn} = '0;
		repeat (3) tick(-1);
		repeat (16) begin
			tick(-1);
			nSync += int'(flagBusSync === 1'b1);
			nExo += int'(expansionOut === 1'b1);
			nOwn += int'(flagBusEn === 1'b1);
		end
		check(nSync, 2, "sync count");
		check(nExo, 2, "expansion count");
		check(nOwn, 2, "poll slot count");
		test_done();
	end
endmodule
`default_nettype wire
